// ### udc_core.sv
// Shared constants and the count register core of the up/down counter
`timescale 1ns/100ps

// ==========================================================
// Constants shared by the core and the bus top
// ==========================================================
package udc_pkg;
  localparam int unsigned UDC_CNT_W = 4;
  localparam int unsigned UDC_DIV_W = 16;
  // Register byte addresses
  localparam logic [31:0] UDC_OFS_CTRL = 32'h0000_0000;
  localparam logic [31:0] UDC_OFS_DIV = 32'h0000_0004;
  localparam logic [31:0] UDC_OFS_STAT = 32'h0000_0008;
  // Control field positions
  localparam int unsigned UDC_CTRL_CEN_N_BIT = 0;
  localparam int unsigned UDC_CTRL_DOWN_BIT = 1;
  localparam int unsigned UDC_CTRL_LOAD_N_BIT = 2;
  localparam int unsigned UDC_CTRL_PRE_LSB = 4;
  // Status field positions
  localparam int unsigned UDC_STAT_TC_BIT = 4;
  localparam int unsigned UDC_STAT_RCO_N_BIT = 5;
  localparam int unsigned UDC_STAT_PHASE_BIT = 6;
  localparam int unsigned UDC_STAT_LOAD_BIT = 7;
  // Values after reset, and the mask of writable control bits
  localparam logic [31:0] UDC_CTRL_RST = 32'h0000_0005;
  localparam logic [31:0] UDC_CTRL_MASK = 32'h0000_00F7;
  localparam logic [UDC_DIV_W-1:0] UDC_DIV_RST = 16'h0003;
  localparam logic [UDC_CNT_W-1:0] UDC_CNT_RST = 4'h0;
  // Bus transfer type bit that marks an active transfer
  localparam int unsigned UDC_HTRANS_ACT_BIT = 1;
  // Phase of the internal count clock, one-hot
  typedef enum logic [1:0] {
    UDC_PH_LOW = 2'b01,
    UDC_PH_HIGH = 2'b10
  } udc_phase_t;
endpackage

// ==========================================================
// Count register: preset, hold, step up or down
// ==========================================================
module udc_core #(
  parameter int unsigned WIDTH = udc_pkg::UDC_CNT_W
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic step,
  input wire logic count_enable_n,
  input wire logic count_down,
  input wire logic load_n,
  input wire logic [WIDTH-1:0] preset,
  output logic [WIDTH-1:0] count_r
);
  import udc_pkg::*;

  // All bits share one edge, so the value never ripples
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_r <= WIDTH'(UDC_CNT_RST);
    end else if (!load_n) begin
      // Preset beats any step while load is held
      count_r <= preset;
    end else if (step && !count_enable_n) begin
      // Controls only matter at the step edge
      if (count_down) begin
        count_r <= count_r - WIDTH'(1);
      end else begin
        count_r <= count_r + WIDTH'(1);
      end
    end
  end

  // ==========================================================
  // Assertions
  // ==========================================================
  a_load_follow: assert property (@(posedge clk) disable iff (!rst_n)
    !load_n |=> count_r == $past(preset))
    else $error("count did not take the preset");
  a_count_hold: assert property (@(posedge clk) disable iff (!rst_n)
    (step && count_enable_n && load_n) |=> $stable(count_r))
    else $error("count moved while inhibited");
  a_no_step: assert property (@(posedge clk) disable iff (!rst_n)
    (!step && load_n) |=> $stable(count_r))
    else $error("count moved without a step");
  a_step_up: assert property (@(posedge clk) disable iff (!rst_n)
    (step && !count_enable_n && !count_down && load_n)
      |=> count_r == WIDTH'($past(count_r) + WIDTH'(1)))
    else $error("up step wrong");
  a_step_down: assert property (@(posedge clk) disable iff (!rst_n)
    (step && !count_enable_n && count_down && load_n)
      |=> count_r == WIDTH'($past(count_r) - WIDTH'(1)))
    else $error("down step wrong");
  a_wrap_up: assert property (@(posedge clk) disable iff (!rst_n)
    (step && !count_enable_n && !count_down && load_n && (&count_r))
      |=> count_r == '0)
    else $error("no wrap from max to zero");
  a_wrap_down: assert property (@(posedge clk) disable iff (!rst_n)
    (step && !count_enable_n && count_down && load_n && (count_r == '0))
      |=> (&count_r))
    else $error("no wrap from zero to max");
  c_wrap_up: cover property (@(posedge clk) disable iff (!rst_n)
    step && !count_enable_n && !count_down && load_n && (&count_r));
  c_wrap_down: cover property (@(posedge clk) disable iff (!rst_n)
    step && !count_enable_n && count_down && load_n && (count_r == '0));
endmodule // udc_core

// ### udc_top.sv
// AHB-Lite top of the presettable 4-bit up/down counter
`timescale 1ns/100ps

// ==========================================================
// Operation
// - Four-bit counter stepping up or down
// - All count bits change on one edge
// - Step only while count enable low
// - Direction low counts up, high down
// - Up count wraps fifteen to zero
// - Down count wraps zero to fifteen
// - Enable and direction move count only at clock edge
// - Load low forces count to preset
// - Terminal flag high at limit; one period while counting
// - Ripple clock low at limit, low phase, while enabled
// ==========================================================
module udc_top #(
  parameter int unsigned CNT_W = udc_pkg::UDC_CNT_W,
  parameter int unsigned DIV_W = udc_pkg::UDC_DIV_W
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic [CNT_W-1:0] count_q,
  output logic terminal_count,
  output logic ripple_clock_n,
  output logic count_clk
);
  import udc_pkg::*;

  // ==========================================================
  // Declarations
  // ==========================================================
  logic take; // Address phase accepted
  logic wr_pend_r; // Write data phase pending
  logic rd_pend_r; // Read data phase pending
  logic [31:0] addr_r; // Word address of the data phase
  logic [3:0] lanes_r; // Byte lanes of the data phase
  logic [31:0] ctrl_r; // Control register
  logic [DIV_W-1:0] div_r; // Half period of the count clock, less one cycle
  logic [31:0] ctrl_nxt; // Control after a write merge
  logic [31:0] div_nxt; // Divider after a write merge
  logic [31:0] stat_word; // Status as read
  logic cen_n; // Count inhibit level
  logic count_down; // Direction
  logic load_n; // Preset hold, active low
  logic [CNT_W-1:0] preset; // Parallel preset value
  logic [CNT_W-1:0] count_r; // Stored count
  udc_phase_t phase_r; // Count clock phase
  logic [DIV_W-1:0] half_cnt_r; // Half period down counter
  logic half_end; // Half period done
  logic step; // Rising edge of the count clock
  logic at_max; // Count at all ones
  logic at_min; // Count at zero

  // ==========================================================
  // Helpers for byte lanes
  // ==========================================================
  // Lanes touched by one transfer
  function automatic logic [3:0] lane_mask(input logic [1:0] a,
                                           input logic [2:0] sz);
    logic [3:0] m;
    m = 4'h0;
    case (sz)
      3'h0: m = 4'h1 << a;
      3'h1: m = a[1] ? 4'hC : 4'h3;
      default: m = 4'hF;
    endcase
    return m;
  endfunction

  // Replace only the written byte lanes
  function automatic logic [31:0] merge(input logic [31:0] old_w,
                                        input logic [31:0] new_w,
                                        input logic [3:0] lanes);
    logic [31:0] r;
    r = old_w;
    for (int i = 0; i < 4; i++) begin
      if (lanes[i]) begin
        r[i*8 +: 8] = new_w[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // ==========================================================
  // Bus slave: address phase capture
  // ==========================================================
  // Zero wait states, so the slave is always ready
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign take = hsel && hready && htrans[UDC_HTRANS_ACT_BIT];

  // Every transfer ends in its first data phase cycle. Byte and halfword
  // writes touch only their own lanes, but the preset shares byte 0 with the
  // enable, direction and load bits, so a preset byte write rewrites them too.
  // Writes to the status word or to an unmapped word are dropped.
  // Latch the transfer for its data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      addr_r <= 32'h0000_0000;
      lanes_r <= 4'h0;
    end else if (hready) begin
      wr_pend_r <= take && hwrite;
      rd_pend_r <= take && !hwrite;
      if (take) begin
        addr_r <= {haddr[31:2], 2'b00};
        lanes_r <= lane_mask(haddr[1:0], hsize);
      end
    end
  end

  // ==========================================================
  // Registers
  // ==========================================================
  assign ctrl_nxt = merge(ctrl_r, hwdata, lanes_r) & UDC_CTRL_MASK;
  assign div_nxt = merge(32'(div_r), hwdata, lanes_r);

  // Control: inhibit and load start high, so it idles
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r <= UDC_CTRL_RST;
    end else if (wr_pend_r && addr_r == UDC_OFS_CTRL) begin
      ctrl_r <= ctrl_nxt;
    end
  end

  // Divider: sets the count clock period
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_r <= DIV_W'(UDC_DIV_RST);
    end else if (wr_pend_r && addr_r == UDC_OFS_DIV) begin
      div_r <= div_nxt[DIV_W-1:0];
    end
  end

  // Control fields
  assign cen_n = ctrl_r[UDC_CTRL_CEN_N_BIT];
  assign count_down = ctrl_r[UDC_CTRL_DOWN_BIT];
  assign load_n = ctrl_r[UDC_CTRL_LOAD_N_BIT];
  assign preset = ctrl_r[UDC_CTRL_PRE_LSB +: CNT_W];

  // ==========================================================
  // Count clock generator
  // ==========================================================
  // Each half lasts div_r + 1 cycles; a new divider
  // takes effect at the next half boundary, not mid-phase
  // The count clock is a level made from hclk, never a clock net: every
  // count flop runs on hclk and moves on the one-cycle step pulse, so the
  // count bits cannot skew against each other.
  // Trade-off: the fastest count rate is half of hclk, with a divider of
  // zero, which still leaves the ripple clock a low phase of one cycle.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      half_cnt_r <= DIV_W'(UDC_DIV_RST);
    end else if (half_end) begin
      half_cnt_r <= div_r;
    end else begin
      half_cnt_r <= half_cnt_r - DIV_W'(1);
    end
  end

  assign half_end = (half_cnt_r == '0);

  // Phase toggles at each half boundary
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_r <= UDC_PH_LOW;
    end else begin
      unique case (phase_r)
        UDC_PH_LOW: begin
          if (half_end) begin
            phase_r <= UDC_PH_HIGH;
          end
        end
        UDC_PH_HIGH: begin
          if (half_end) begin
            phase_r <= UDC_PH_LOW;
          end
        end
        // Recover from an illegal code
        default: phase_r <= UDC_PH_LOW;
      endcase
    end
  end

  // Rising edge of the count clock, one cycle wide
  assign step = half_end && (phase_r == UDC_PH_LOW);
  assign count_clk = (phase_r == UDC_PH_HIGH);

  // ==========================================================
  // Count register
  // ==========================================================
  udc_core #(
    .WIDTH(CNT_W)
  ) u_core (
    .clk(hclk),
    .rst_n(hresetn),
    .step(step),
    .count_enable_n(cen_n),
    .count_down(count_down),
    .load_n(load_n),
    .preset(preset),
    .count_r(count_r)
  );

  // ==========================================================
  // Outputs to cascaded stages
  // ==========================================================
  // Both cascade outputs are combinational from flops: a turn of the
  // direction bit at a limit moves the terminal flag without a step, and
  // a cascaded stage must sample them on hclk, never use them as a clock.
  // Preset shows at once, not at the next step
  assign count_q = load_n ? count_r : preset;
  assign at_max = &count_q;
  assign at_min = (count_q == '0);
  // Limit depends on direction; lasts one count period while counting
  assign terminal_count = count_down ? at_min : at_max;
  // Low half only, so a next stage sees a clean rise
  assign ripple_clock_n = ~(terminal_count && !cen_n &&
                            (phase_r == UDC_PH_LOW));

  // ==========================================================
  // Read data
  // ==========================================================
  // Status shows the live count and cascade outputs
  always_comb begin
    stat_word = 32'h0000_0000;
    stat_word[CNT_W-1:0] = count_q;
    stat_word[UDC_STAT_TC_BIT] = terminal_count;
    stat_word[UDC_STAT_RCO_N_BIT] = ripple_clock_n;
    stat_word[UDC_STAT_PHASE_BIT] = count_clk;
    stat_word[UDC_STAT_LOAD_BIT] = !load_n;
  end

  // Unmapped words read zero
  always_comb begin
    hrdata = 32'h0000_0000;
    if (rd_pend_r) begin
      if (addr_r == UDC_OFS_CTRL) begin
        hrdata = ctrl_r;
      end else if (addr_r == UDC_OFS_DIV) begin
        hrdata = 32'(div_r);
      end else if (addr_r == UDC_OFS_STAT) begin
        hrdata = stat_word;
      end
    end
  end

  // ==========================================================
  // Assertions
  // ==========================================================
  a_rco_phase: assert property (@(posedge hclk) disable iff (!hresetn)
    !ripple_clock_n |-> (terminal_count && !cen_n && !count_clk))
    else $error("ripple clock low outside its window");
  a_rco_inhibit: assert property (@(posedge hclk) disable iff (!hresetn)
    cen_n |-> ripple_clock_n)
    else $error("ripple clock low while inhibited");
  a_rco_high_ph: assert property (@(posedge hclk) disable iff (!hresetn)
    count_clk |-> ripple_clock_n)
    else $error("ripple clock low in high phase");
  a_tc_one_period: assert property (@(posedge hclk) disable iff (!hresetn)
    (step && terminal_count && !cen_n && load_n) ##1 $stable(ctrl_r)
      |-> !terminal_count)
    else $error("terminal flag outlived one period");
  a_tc_up_max: assert property (@(posedge hclk) disable iff (!hresetn)
    (step && !cen_n && !count_down && load_n && count_r == CNT_W'(14))
      ##1 $stable(ctrl_r) |-> terminal_count)
    else $error("terminal flag missing at max");
  a_step_gap: assert property (@(posedge hclk) disable iff (!hresetn)
    step |=> !step)
    else $error("count clock edges too close");

  // Terminal flag at the lower limit when counting down
  a_tc_down_min: assert property (@(posedge hclk) disable iff (!hresetn)
    (step && !cen_n && count_down && load_n && count_r == CNT_W'(1))
      ##1 $stable(ctrl_r) |-> terminal_count)
    else $error("terminal flag missing at min");
  a_tc_inhibit: assert property (@(posedge hclk) disable iff (!hresetn)
    (cen_n && load_n && count_down && count_r == '0) |-> terminal_count)
    else $error("terminal flag lost while inhibited");

  // Preset shows at once and is the start of the next count
  a_preset_shown: assert property (@(posedge hclk) disable iff (!hresetn)
    !load_n |-> count_q == preset)
    else $error("count output ignores the preset");
  a_load_resume: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(load_n) |-> count_r == $past(preset))
    else $error("count lost the preset at release");

  // Count clock shape: a rise at each step, steady inside a half
  a_step_rise: assert property (@(posedge hclk) disable iff (!hresetn)
    step |=> count_clk)
    else $error("count clock did not rise at a step");
  a_phase_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    !half_end |=> $stable(phase_r))
    else $error("count clock moved inside a half period");

  // Bus side: whole-word writes land, control through its writable mask, status is read only
  a_ctrl_write: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_pend_r && addr_r == UDC_OFS_CTRL && lanes_r == 4'hF)
      |=> ctrl_r == ($past(hwdata) & UDC_CTRL_MASK))
    else $error("control write did not land");
  a_div_write: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_pend_r && addr_r == UDC_OFS_DIV && lanes_r == 4'hF)
      |=> div_r == $past(hwdata[DIV_W-1:0]))
    else $error("divider write did not land");
  a_stat_ro: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_pend_r && addr_r == UDC_OFS_STAT) |=> ($stable(ctrl_r) && $stable(div_r)))
    else $error("status write changed a register");
  a_ctrl_clean: assert property (@(posedge hclk) disable iff (!hresetn)
    (ctrl_r & ~UDC_CTRL_MASK) == 32'h0000_0000)
    else $error("reserved control bits set");
  a_rd_idle: assert property (@(posedge hclk) disable iff (!hresetn)
    !rd_pend_r |-> hrdata == 32'h0000_0000)
    else $error("read data outside a data phase");

  // ==========================================================
  // Cover points
  // ==========================================================
  // Main scenarios: a ripple pulse, a load then count, a down wrap
  c_rco_pulse: cover property (@(posedge hclk) disable iff (!hresetn)
    !ripple_clock_n ##1 ripple_clock_n);
  c_load_then_count: cover property (@(posedge hclk) disable iff (!hresetn)
    !load_n ##1 load_n ##[1:40] (step && !cen_n));
  c_wrap_round: cover property (@(posedge hclk) disable iff (!hresetn)
    step && !cen_n && count_down && terminal_count);
endmodule // udc_top

// ### udc_next_stage.sv
// Model of the next cascaded counter stage fed by the ripple clock
`timescale 1ns/100ps

// ==========================================================
// Upper stage: parallel clocking, ripple clock used as its enable
// ==========================================================
module udc_next_stage (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic count_clk,
  input wire logic ripple_clock_n,
  input wire logic terminal_count,
  input wire logic down,
  output logic [3:0] upper_count,
  output logic carry_ahead
);
  logic clk_d_r; // Count clock as seen at the last edge
  logic rco_d_r; // Ripple clock as seen at the last edge
  logic [3:0] upper_r; // Upper stage count

  // Look-ahead carry taken straight from the lower flag, ahead of the ripple
  assign carry_ahead = terminal_count;
  assign upper_count = upper_r;

  // Sample shared clock and enable; a step needs both from one edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clk_d_r <= 1'b0;
      rco_d_r <= 1'b1;
    end else begin
      clk_d_r <= count_clk;
      rco_d_r <= ripple_clock_n;
    end
  end

  // Step only on a count clock rise that met a low ripple clock
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      upper_r <= 4'h0;
    end else if (count_clk && !clk_d_r && !rco_d_r) begin
      upper_r <= down ? upper_r - 4'h1 : upper_r + 4'h1;
    end
  end
endmodule // udc_next_stage

// ### test_presettable_up_down_counter_4bit.sv
// Self-checking testbench of the presettable up/down counter
`timescale 1ns/100ps

// ==========================================================
// Bench top: bus tasks, count watchers and verdict
// ==========================================================
module test_presettable_up_down_counter_4bit;
  import udc_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd_q, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic terminal_count, ripple_clock_n, count_clk, carry_ahead;
  logic [3:0] count_q, upper_count;
  logic dn, en; // Bench copy of direction and enable as last written
  int errors, checked;

  // Single slave: its ready is the bus ready
  udc_top #(.CNT_W(4), .DIV_W(16)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .count_q(count_q), .terminal_count(terminal_count),
    .ripple_clock_n(ripple_clock_n), .count_clk(count_clk));

  udc_next_stage nxt (.hclk(hclk), .hresetn(hresetn), .count_clk(count_clk),
    .ripple_clock_n(ripple_clock_n), .terminal_count(terminal_count), .down(dn),
    .upper_count(upper_count), .carry_ahead(carry_ahead));

  // 125 MHz clock
  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end

  // Read data captured at the edge, free of any race with the flops
  always @(posedge hclk) rd_q <= hrdata;

  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Verdict and end of run
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Bounded wait for ready at a rising edge
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 100);
    if (hreadyout !== 1'b1) begin
      errors++;
      finish_test();
    end
  endtask

  // One single word transfer; read data lands in rd
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= 3'h2;
    wait_rdy();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wr ? d : 32'h0;
    wait_rdy();
    #1 rd = rd_q;
    chk(hresp, 32'h0);
  endtask

  // Control write, keeping the bench copy of the mode in step
  task automatic ctrl(input logic [31:0] d);
    bus(1'b1, UDC_OFS_CTRL, d);
    en = !d[0];
    dn = d[1];
  endtask

  // Terminal flag and ripple clock worked out from count and mode
  task automatic chk_term();
    logic t;
    t = (count_q === (dn ? 4'h0 : 4'hF));
    chk(terminal_count, t);
    chk(ripple_clock_n, !(t && en && !count_clk));
  endtask

  // Wait for the next count change and check the new value
  task automatic step_to(input logic [3:0] exp);
    logic [3:0] prev;
    int n;
    prev = count_q;
    n = 0;
    do begin
      @(negedge hclk);
      chk_term();
      n++;
    end while (count_q === prev && n < 100);
    chk(count_q, exp);
    chk(count_clk, 1'b1);
    if (count_q === prev) begin
      finish_test();
    end
  endtask

  // Count must stand for n cycles
  task automatic hold(input int n, input logic [3:0] v);
    repeat (n) begin
      @(negedge hclk);
      chk_term();
      chk(count_q, v);
    end
  endtask

  // ==========================================================
  // Main sequence
  // ==========================================================
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    errors = 0;
    checked = 0;
    en = 1'b0;
    dn = 1'b0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    // Reset values, unmapped place, slow count clock so writes land between steps
    bus(1'b0, UDC_OFS_CTRL, 32'h0);
    chk(rd, UDC_CTRL_RST);
    bus(1'b0, 32'h0000_000C, 32'h0);
    chk(rd, 32'h0);
    bus(1'b1, UDC_OFS_DIV, 32'h0000_0007);
    bus(1'b0, UDC_OFS_DIV, 32'h0);
    chk(rd, 32'h0000_0007);
    hold(4, 4'h0);
    // Preset to 13 while inhibited, then release the load
    ctrl(32'h0000_00D1);
    chk(count_q, 4'hD);
    bus(1'b0, UDC_OFS_STAT, 32'h0);
    chk(rd & 32'hFFFF_FFBF, 32'h0000_00AD);
    ctrl(32'h0000_00D5);
    hold(6, 4'hD);
    // Count up through the wrap
    ctrl(32'h0000_00D4);
    step_to(4'hE);
    step_to(4'hF);
    step_to(4'h0);
    step_to(4'h1);
    chk(upper_count, 4'h1);
    step_to(4'h2);
    // Inhibit, then turn round; mode change alone leaves the count
    ctrl(32'h0000_00D5);
    hold(6, 4'h2);
    ctrl(32'h0000_00D6);
    chk(count_q, 4'h2);
    step_to(4'h1);
    step_to(4'h0);
    // Inhibited at the minimum: flag stays, ripple clock stays high
    ctrl(32'h0000_00D7);
    hold(6, 4'h0);
    chk(carry_ahead, 1'b1);
    ctrl(32'h0000_00D6);
    step_to(4'hF);
    step_to(4'hE);
    chk(upper_count, 4'h0);
    step_to(4'hD);
    // Load while enabled wins; after release the count steps up from the preset
    ctrl(32'h0000_0090);
    chk(count_q, 4'h9);
    hold(20, 4'h9);
    ctrl(32'h0000_0094);
    step_to(4'hA);
    finish_test();
  end
endmodule // test_presettable_up_down_counter_4bit
